// ===== bench/hmcd_chk_sva.sv
// concurrent checks on the hardware-mode pin decoder ports
`default_nettype none
module hmcd_chk
    import hmcd_pkg::*;
(
    input wire logic clk, // clock
    input wire logic rst, // reset
    input wire logic hw_reset_n, // reset pin
    input wire logic dev_in_reset, // reset state
    input wire logic ctrl_if_sel_hi, // mode pin
    input wire logic ctrl_if_sel_lo, // mode pin
    input wire logic [1:0] ctrl_if_mode, // mode out
    input wire logic tx_pattern_sel_ch2_hi, // pattern pin
    input wire logic tx_pattern_sel_ch2_lo, // pattern pin
    input wire logic tx_normal_ch2, // pattern out
    input wire logic tx_all_ones_ch2, // pattern out
    input wire logic tx_prbs_ch2, // pattern out
    input wire logic tx_powerdown_ch2, // pattern out
    input wire logic rx_powerdown_ch1, // rx pin
    input wire logic rx_pd_ch1, // rx out
    input wire logic jitter_atten_sel_hi, // ja pin
    input wire logic jitter_atten_sel_lo, // ja pin
    input wire logic ja_enable, // ja out
    input wire logic ja_in_tx, // ja out
    input wire logic ja_narrow_bw, // ja out
    input wire logic ja_fifo_128, // ja out
    input wire logic pulse_template_sel_ch2, // pulse pin
    input wire logic imp_120_ch2, // impedance out
    input wire logic rd_stb, // read strobe
    input wire logic data_oe // read answer
);
    logic [2:0] hw_cnt_ff;
    logic [2:0] nxt_hw_cnt;
    logic hw_steady;
    logic [1:0] mode_pin;
    logic [1:0] ja_pin;
    logic [3:0] ja_dec;
    logic [3:0] patt_dec;
    // history only trusted after the pin pipeline has refilled in hw mode
    assign nxt_hw_cnt = (ctrl_if_mode != 2'h0 || dev_in_reset) ? 3'h0 :
        hw_cnt_ff + {2'h0, hw_cnt_ff != 3'h7};
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            hw_cnt_ff <= 3'h0;
        else
            hw_cnt_ff <= nxt_hw_cnt;
    end
    assign hw_steady = hw_cnt_ff == 3'h7;
    assign mode_pin = {ctrl_if_sel_hi, ctrl_if_sel_lo};
    assign ja_pin = {jitter_atten_sel_hi, jitter_atten_sel_lo};
    assign ja_dec = {|ja_pin, &ja_pin, ja_pin[1], ja_pin[1]};
    assign patt_dec = 4'h1 << {tx_pattern_sel_ch2_hi, tx_pattern_sel_ch2_lo};
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_patt_decode: assert property (hw_steady |->
        {tx_powerdown_ch2, tx_prbs_ch2, tx_all_ones_ch2, tx_normal_ch2} == $past(patt_dec, 4))
        else $error("pattern decode wrong");
    a_rx_pd: assert property (hw_steady |-> rx_pd_ch1 == $past(rx_powerdown_ch1, 4))
        else $error("receiver power down wrong");
    a_ja_decode: assert property (hw_steady |->
        {ja_enable, ja_in_tx, ja_narrow_bw, ja_fifo_128} == $past(ja_dec, 4))
        else $error("jitter decode wrong");
    a_imp_sel: assert property (hw_steady |->
        imp_120_ch2 == ($past(pulse_template_sel_ch2, 4) == PULS_120_LEVEL))
        else $error("impedance select wrong");
    a_rst_qual: assert property (!hw_reset_n [*5] |-> ##[0:2] dev_in_reset)
        else $error("long reset pulse not taken");
    a_rst_release: assert property (hw_reset_n [*3] |=> !dev_in_reset)
        else $error("reset state not left");
    a_mode_follow: assert property ((!dev_in_reset && $stable(mode_pin)) [*5]
        |=> ctrl_if_mode == $past(mode_pin))
        else $error("control mode wrong");
    a_read_oe: assert property (data_oe ==
        $past(rd_stb && ctrl_if_mode[1] && !dev_in_reset))
        else $error("data drive wrong");
    a_rst_default: assert property (dev_in_reset [*3] |-> tx_normal_ch2 && !rx_pd_ch1
        && !ja_enable && !imp_120_ch2 && !data_oe)
        else $error("outputs not at defaults in reset");
    c_par_read: cover property (rd_stb && ctrl_if_mode[1] ##1 data_oe);
    c_hw_reset: cover property ($rose(dev_in_reset));
    c_ja_tx: cover property (hw_steady && ja_in_tx);
endmodule // hmcd_chk
bind hmcd_top hmcd_chk chk_u (.clk, .rst, .hw_reset_n, .dev_in_reset, .ctrl_if_sel_hi,
    .ctrl_if_sel_lo, .ctrl_if_mode, .tx_pattern_sel_ch2_hi, .tx_pattern_sel_ch2_lo,
    .tx_normal_ch2, .tx_all_ones_ch2, .tx_prbs_ch2, .tx_powerdown_ch2, .rx_powerdown_ch1,
    .rx_pd_ch1, .jitter_atten_sel_hi, .jitter_atten_sel_lo, .ja_enable, .ja_in_tx,
    .ja_narrow_bw, .ja_fifo_128, .pulse_template_sel_ch2, .imp_120_ch2, .rd_stb, .data_oe);
`default_nettype wire

// ===== bench/hmcd_strap.sv
// board strapping model driving the static configuration pins
`default_nettype none
module hmcd_strap
    import hmcd_pkg::*;
(
    input wire logic clk, // master clock
    input wire logic [hmcd_pkg::PIN_W-1:0] strap_req, // wanted levels
    output logic [hmcd_pkg::PIN_W-1:0] strap_pins // pin levels
);
    // reset held long, clock free running
    // pins move just after an edge, like a switch settling on the board
    always @(posedge clk)
    begin
        strap_pins <= strap_req;
    end
endmodule // hmcd_strap
`default_nettype wire

// ===== bench/hmcd_top_tb.sv
// testbench for the hardware-mode pin decoder
`default_nettype none
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin bad_count++; \
    $display("MISMATCH %s exp %h got %h", n, e, s); end end
module hmcd_top_tb
    import hmcd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [PIN_W-1:0] req = '0;
    logic [PIN_W-1:0] pins;
    logic [ADDR_W-1:0] addr = '0;
    logic [DATA_W-1:0] host_d = '0;
    logic [DATA_W-1:0] data_in, data_out;
    logic wr_stb = 1'b0;
    logic rd_stb = 1'b0;
    logic [1:0] ctrl_if_mode;
    logic data_oe, dev_in_reset, tx_normal_ch2, tx_all_ones_ch2, tx_prbs_ch2, tx_powerdown_ch2;
    logic rx_pd_ch1, rx_pd_ch2, ja_enable, ja_in_tx, ja_narrow_bw, ja_fifo_128;
    logic mon_gain_26db_ch1, mon_gain_26db_ch2, ext_match_ch1, ext_match_ch2, imp_120_ch2;
    int bad_count = 0;
    int n_compared = 0;
    int tick = 0;
    logic [3:0] patt_oh;
    logic [3:0] ja_vec;
    assign patt_oh = {tx_powerdown_ch2, tx_prbs_ch2, tx_all_ones_ch2, tx_normal_ch2};
    assign ja_vec = {ja_enable, ja_in_tx, ja_narrow_bw, ja_fifo_128};
    // level seen on the shared data pins
    assign data_in = data_oe ? data_out : host_d;
    hmcd_strap strap_u (.clk, .strap_req(req), .strap_pins(pins));
    hmcd_top dut_u (.clk, .rst, .hw_reset_n(pins[PIN_RST_N]),
        .ctrl_if_sel_hi(pins[PIN_MODE_HI]), .ctrl_if_sel_lo(pins[PIN_MODE_LO]),
        .tx_pattern_sel_ch2_hi(pins[PIN_PATT_HI]), .tx_pattern_sel_ch2_lo(pins[PIN_PATT_LO]),
        .rx_powerdown_ch1(pins[PIN_RX_POWERDOWN_CH1]), .rx_powerdown_ch2(pins[PIN_RX_POWERDOWN_CH2]),
        .jitter_atten_sel_hi(pins[PIN_JA_HI]), .jitter_atten_sel_lo(pins[PIN_JA_LO]),
        .monitor_gain_sel_ch1(pins[PIN_MONITOR_GAIN_SEL_CH1]), .monitor_gain_sel_ch2(pins[PIN_MONITOR_GAIN_SEL_CH2]),
        .termination_sel_ch1(pins[PIN_TERMINATION_SEL_CH1]), .termination_sel_ch2(pins[PIN_TERMINATION_SEL_CH2]),
        .pulse_template_sel_ch2(pins[PIN_PULSE_TEMPLATE_SEL_CH2]), .addr, .data_in, .wr_stb, .rd_stb,
        .data_out, .data_oe, .dev_in_reset, .ctrl_if_mode, .tx_normal_ch2, .tx_all_ones_ch2,
        .tx_prbs_ch2, .tx_powerdown_ch2, .rx_pd_ch1, .rx_pd_ch2, .ja_enable, .ja_in_tx,
        .ja_narrow_bw, .ja_fifo_128, .mon_gain_26db_ch1, .mon_gain_26db_ch2, .ext_match_ch1,
        .ext_match_ch2, .imp_120_ch2);
    initial
    begin
        forever #25 clk = ~clk;
    end
    function automatic logic [PIN_W-1:0] pv(input logic [1:0] m, input logic [1:0] i);
        logic [PIN_W-1:0] v;
        v = '0;
        v[PIN_RST_N] = 1'b1;
        v[PIN_MODE_HI:PIN_MODE_LO] = m;
        v[PIN_PATT_HI:PIN_PATT_LO] = i;
        v[PIN_JA_HI:PIN_JA_LO] = i;
        v[PIN_RX_POWERDOWN_CH1] = i[0];
        v[PIN_RX_POWERDOWN_CH2] = i[1];
        v[PIN_MONITOR_GAIN_SEL_CH1] = i[0];
        v[PIN_MONITOR_GAIN_SEL_CH2] = i[1];
        v[PIN_TERMINATION_SEL_CH1] = i[1];
        v[PIN_TERMINATION_SEL_CH2] = i[0];
        v[PIN_PULSE_TEMPLATE_SEL_CH2] = i[0];
        return v;
    endfunction
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // sync, decode and strap delay all fit well inside eight cycles
    task automatic strap(input logic [PIN_W-1:0] v);
        @(posedge clk);
        req <= v;
        cyc(8);
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk);
        addr <= a;
        host_d <= d;
        wr_stb <= 1'b1;
        @(posedge clk);
        wr_stb <= 1'b0;
        addr <= '0;
        // released bus shows the inverse of the last write
        host_d <= ~d;
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, input logic oe, input logic [DATA_W-1:0] d);
        @(posedge clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge clk);
        rd_stb <= 1'b0;
        addr <= '0;
        #1;
        `CHK("rd_oe", oe, data_oe)
        `CHK("rd_data", d, data_out)
    endtask
    task automatic t_reset();
        cyc(4);
        `CHK("in_reset", 1'b1, dev_in_reset)
        `CHK("rx_pd_held", 1'b0, rx_pd_ch1)
        `CHK("normal", 1'b1, tx_normal_ch2)
        strap(pv(2'h0, 2'h0));
        `CHK("released", 1'b0, dev_in_reset)
        $display("done t_reset");
    endtask
    task automatic t_hw();
        logic [3:0] ja_tab [4] = '{4'h0, 4'h8, 4'hb, 4'hf};
        for (int k = 0; k < 4; k++)
        begin
            strap(pv(2'h0, k[1:0]));
            `CHK("patt", 4'h1 << k[1:0], patt_oh)
            `CHK("rx_pd", k[1:0], {rx_pd_ch2, rx_pd_ch1})
            `CHK("ja", ja_tab[k], ja_vec)
            `CHK("mon", k[1:0], {mon_gain_26db_ch2, mon_gain_26db_ch1})
            `CHK("ext", k[1:0], {ext_match_ch1, ext_match_ch2})
            `CHK("imp", k[0] == PULS_120_LEVEL, imp_120_ch2)
            `CHK("mode_hw", 2'h0, ctrl_if_mode)
        end
        $display("done t_hw");
    endtask
    task automatic t_pulse();
        @(posedge clk);
        req[PIN_RST_N] <= 1'b0;
        repeat (2) @(posedge clk);
        req[PIN_RST_N] <= 1'b1;
        cyc(8);
        `CHK("short_low", 1'b0, dev_in_reset)
        @(posedge clk);
        req[PIN_RST_N] <= 1'b0;
        cyc(8);
        `CHK("long_low", 1'b1, dev_in_reset)
        `CHK("dflt_patt", 1'b1, tx_normal_ch2)
        strap(pv(2'h0, 2'h0));
        `CHK("rerelease", 1'b0, dev_in_reset)
        $display("done t_pulse");
    endtask
    task automatic t_serial();
        strap(pv(2'h1, 2'h3));
        `CHK("mode_ser", 2'h1, ctrl_if_mode)
        `CHK("ja_ignored", 1'b0, ja_enable)
        wr(REG_CFG_A, 8'hff);
        rd(REG_CFG_A, 1'b0, 8'h00);
        $display("done t_serial");
    endtask
    task automatic t_par();
        strap(pv(2'h2, 2'h0));
        `CHK("mode_par_a", 2'h2, ctrl_if_mode)
        rd(REG_CFG_A, 1'b1, 8'h00);
        wr(REG_CFG_A, 8'hb6);
        wr(REG_CFG_B, 8'h05);
        rd(REG_CFG_A, 1'b1, 8'hb6);
        rd(REG_CFG_B, 1'b1, 8'h05);
        rd(6'h3f, 1'b1, 8'h00);
        rd(REG_STATUS, 1'b1, 8'h06);
        `CHK("ja_reg", 4'hf, ja_vec)
        `CHK("patt_reg", 4'h4, patt_oh)
        `CHK("rx_reg", 1'b1, rx_pd_ch1)
        `CHK("mon_reg", 2'h2, {mon_gain_26db_ch2, mon_gain_26db_ch1})
        `CHK("ext_reg", 2'h1, {ext_match_ch2, ext_match_ch1})
        `CHK("imp_reg", PULS_120_LEVEL == 1'b1, imp_120_ch2)
        strap(pv(2'h3, 2'h0));
        `CHK("mode_par_b", 2'h3, ctrl_if_mode)
        rd(REG_EFF_A, 1'b1, 8'hb6);
        rd(REG_EFF_B, 1'b1, 8'h05);
        $display("done t_par");
    endtask
    task automatic complete_run();
        $display("compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    always @(posedge clk)
    begin
        tick <= tick + 1;
        if (tick == 2000)
        begin
            bad_count++;
            complete_run();
        end
    end
    initial
    begin
        req[PIN_RX_POWERDOWN_CH1] = 1'b1;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_hw();
        t_pulse();
        t_serial();
        t_par();
        complete_run();
    end
endmodule // hmcd_top_tb
`default_nettype wire

// ===== design/hmcd_pkg.sv
// constants and types for the hardware-mode pin configuration decoder
//
// Summary of operation
// [RULE_01] ch2 pattern: normal, ones, prbs, powerdown
// [RULE_02] each receiver powers down on high input
// [RULE_03] jitter select: off, rx broad, rx/tx narrow
// [RULE_04] jitter pins ignored outside hardware mode
// [RULE_05] monitor gain low 0dB, high 26dB
// [RULE_06] termination low internal, high external network
// [RULE_07] ch2 pulse input picks template and impedance
// [RULE_08] reset pin low over 100ns resets device
// [RULE_09] six address bits carry register address
// [RULE_10] data pins driven by device on reads
// [RULE_11] two mode pins choose control interface
// [RULE_12] pins synchronised, settings applied after reset
`default_nettype none
package hmcd_pkg;

    typedef enum logic [1:0] {IF_HW, IF_SERIAL, IF_PAR_A, IF_PAR_B} hmcd_if_t;

    // clock and reset qualification timing
    localparam int CLK_PERIOD_NS = 50;
    localparam int RST_MIN_NS = 100;
    localparam int RST_QUAL_CYC = (RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RST_CNT_W = 3;

    // synchronised pin vector layout
    localparam int PIN_W = 14;
    localparam int PIN_PATT_LO = 0;
    localparam int PIN_PATT_HI = 1;
    localparam int PIN_RX_POWERDOWN_CH1 = 2;
    localparam int PIN_RX_POWERDOWN_CH2 = 3;
    localparam int PIN_JA_LO = 4;
    localparam int PIN_JA_HI = 5;
    localparam int PIN_MONITOR_GAIN_SEL_CH1 = 6;
    localparam int PIN_MONITOR_GAIN_SEL_CH2 = 7;
    localparam int PIN_TERMINATION_SEL_CH1 = 8;
    localparam int PIN_TERMINATION_SEL_CH2 = 9;
    localparam int PIN_PULSE_TEMPLATE_SEL_CH2 = 10;
    localparam int PIN_MODE_LO = 11;
    localparam int PIN_MODE_HI = 12;
    localparam int PIN_RST_N = 13;
    localparam logic [PIN_W-1:0] PIN_SYNC_RST = 14'h0000;

    // register port
    localparam int ADDR_W = 6;
    localparam int DATA_W = 8;
    localparam logic [ADDR_W-1:0] REG_CFG_A = 6'h00;
    localparam logic [ADDR_W-1:0] REG_CFG_B = 6'h01;
    localparam logic [ADDR_W-1:0] REG_STATUS = 6'h02;
    localparam logic [ADDR_W-1:0] REG_EFF_A = 6'h03;
    localparam logic [ADDR_W-1:0] REG_EFF_B = 6'h04;

    // configuration word: cfg_a in [7:0], cfg_b in [10:8]
    localparam int CFG_W = 11;
    localparam int CF_PATT = 0;
    localparam int CF_RX_POWERDOWN_CH1 = 2;
    localparam int CF_RX_POWERDOWN_CH2 = 3;
    localparam int CF_JA = 4;
    localparam int CF_MONITOR_GAIN_SEL_CH1 = 6;
    localparam int CF_MONITOR_GAIN_SEL_CH2 = 7;
    localparam int CF_TERMINATION_SEL_CH1 = 8;
    localparam int CF_TERMINATION_SEL_CH2 = 9;
    localparam int CF_PULSE_TEMPLATE_SEL_CH2 = 10;
    localparam logic [CFG_W-1:0] CFG_RST = 11'h000;

    // field encodings
    localparam logic [1:0] PATT_NORMAL = 2'h0;
    localparam logic [1:0] PATT_ONES = 2'h1;
    localparam logic [1:0] PATT_PRBS = 2'h2;
    localparam logic [1:0] PATT_TXPD = 2'h3;
    localparam logic [1:0] JA_OFF = 2'h0;
    localparam logic [1:0] JA_RX_BROAD = 2'h1;
    localparam logic [1:0] JA_RX_NARROW = 2'h2;
    localparam logic [1:0] JA_TX_NARROW = 2'h3;
    // pulse select level that means 120 ohm; arbitrary polarity choice
    localparam logic PULS_120_LEVEL = 1'b1;

endpackage : hmcd_pkg
`default_nettype wire

// ===== design/hmcd_sync.sv
// two-flop synchroniser for the static configuration pins
`default_nettype none
module hmcd_sync
    import hmcd_pkg::*;
(
    input wire logic clk, // master clock
    input wire logic rst, // async reset
    input wire logic [hmcd_pkg::PIN_W-1:0] pin_in, // raw pins
    output logic [hmcd_pkg::PIN_W-1:0] pin_sync // synchronised pins
);
    logic [PIN_W-1:0] meta_ff;
    logic [PIN_W-1:0] sync_ff;

    // [RULE_12] pin synchronisation
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            meta_ff <= PIN_SYNC_RST;
            sync_ff <= PIN_SYNC_RST;
        end
        else
        begin
            meta_ff <= pin_in;
            sync_ff <= meta_ff;
        end
    end

    assign pin_sync = sync_ff;

endmodule // hmcd_sync
`default_nettype wire

// ===== design/hmcd_top.sv
// hardware-mode configuration pin decoder with parallel register port
//
// Design decisions made here: strobed register access and the register addresses.
`default_nettype none
module hmcd_top
    import hmcd_pkg::*;
(
    input wire logic clk, // master clock, 20 MHz
    input wire logic rst, // async power-on reset, active high
    input wire logic hw_reset_n, // hardware reset pin, active low
    input wire logic ctrl_if_sel_hi, // control mode select bit 1
    input wire logic ctrl_if_sel_lo, // control mode select bit 0
    input wire logic tx_pattern_sel_ch2_hi, // ch2 pattern bit 1
    input wire logic tx_pattern_sel_ch2_lo, // ch2 pattern bit 0
    input wire logic rx_powerdown_ch1, // receiver 1 power down
    input wire logic rx_powerdown_ch2, // receiver 2 power down
    input wire logic jitter_atten_sel_hi, // jitter select bit 1
    input wire logic jitter_atten_sel_lo, // jitter select bit 0
    input wire logic monitor_gain_sel_ch1, // ch1 monitor gain
    input wire logic monitor_gain_sel_ch2, // ch2 monitor gain
    input wire logic termination_sel_ch1, // ch1 matching network
    input wire logic termination_sel_ch2, // ch2 matching network
    input wire logic pulse_template_sel_ch2, // ch2 template/impedance
    input wire logic [hmcd_pkg::ADDR_W-1:0] addr, // register address
    input wire logic [hmcd_pkg::DATA_W-1:0] data_in, // data pins, input side
    input wire logic wr_stb, // write strobe
    input wire logic rd_stb, // read strobe
    output logic [hmcd_pkg::DATA_W-1:0] data_out, // data pins, output side
    output logic data_oe, // data pins driven by device
    output logic dev_in_reset, // device held in reset
    output logic [1:0] ctrl_if_mode, // active control interface
    output logic tx_normal_ch2, // ch2 sends normal data
    output logic tx_all_ones_ch2, // ch2 sends all ones
    output logic tx_prbs_ch2, // ch2 sends prbs
    output logic tx_powerdown_ch2, // ch2 transmitter powered down
    output logic rx_pd_ch1, // receiver 1 powered down
    output logic rx_pd_ch2, // receiver 2 powered down
    output logic ja_enable, // jitter attenuator in use
    output logic ja_in_tx, // attenuator in transmit path
    output logic ja_narrow_bw, // narrow bandwidth selected
    output logic ja_fifo_128, // 128-bit fifo, else 64-bit
    output logic mon_gain_26db_ch1, // ch1 monitor gain 26dB
    output logic mon_gain_26db_ch2, // ch2 monitor gain 26dB
    output logic ext_match_ch1, // ch1 external matching network
    output logic ext_match_ch2, // ch2 external matching network
    output logic imp_120_ch2 // ch2 120 ohm template, else 75 ohm
);
    import hmcd_pkg::*;

    logic [PIN_W-1:0] pin_raw;
    logic [PIN_W-1:0] pin_s;
    logic [RST_CNT_W-1:0] low_cnt_ff;
    logic [RST_CNT_W-1:0] nxt_low_cnt;
    logic in_reset_ff;
    logic nxt_in_reset;
    hmcd_if_t mode_ff;
    hmcd_if_t nxt_mode;
    logic [7:0] cfg_a_ff;
    logic [2:0] cfg_b_ff;
    logic [CFG_W-1:0] eff_ff;
    logic [CFG_W-1:0] nxt_eff;
    logic [CFG_W-1:0] pin_cfg;
    logic [CFG_W-1:0] sw_cfg;
    logic [DATA_W-1:0] rd_data_ff;
    logic [DATA_W-1:0] nxt_rd_data;
    logic rd_oe_ff;
    logic mode_is_hw;
    logic mode_is_par;
    logic reg_wr;
    logic reg_rd;
    logic hw_rst_low;
    logic rst_qualified;
    logic [1:0] patt;
    logic [1:0] ja;

    // pin vector order is fixed in the package so sync and decode agree
    assign pin_raw[PIN_PATT_LO] = tx_pattern_sel_ch2_lo;
    assign pin_raw[PIN_PATT_HI] = tx_pattern_sel_ch2_hi;
    assign pin_raw[PIN_RX_POWERDOWN_CH1] = rx_powerdown_ch1;
    assign pin_raw[PIN_RX_POWERDOWN_CH2] = rx_powerdown_ch2;
    assign pin_raw[PIN_JA_LO] = jitter_atten_sel_lo;
    assign pin_raw[PIN_JA_HI] = jitter_atten_sel_hi;
    assign pin_raw[PIN_MONITOR_GAIN_SEL_CH1] = monitor_gain_sel_ch1;
    assign pin_raw[PIN_MONITOR_GAIN_SEL_CH2] = monitor_gain_sel_ch2;
    assign pin_raw[PIN_TERMINATION_SEL_CH1] = termination_sel_ch1;
    assign pin_raw[PIN_TERMINATION_SEL_CH2] = termination_sel_ch2;
    assign pin_raw[PIN_PULSE_TEMPLATE_SEL_CH2] = pulse_template_sel_ch2;
    assign pin_raw[PIN_MODE_LO] = ctrl_if_sel_lo;
    assign pin_raw[PIN_MODE_HI] = ctrl_if_sel_hi;
    assign pin_raw[PIN_RST_N] = hw_reset_n;

    // [RULE_12] every pin through two flops
    hmcd_sync u_sync (
        .clk(clk),
        .rst(rst),
        .pin_in(pin_raw),
        .pin_sync(pin_s)
    );

    // reset pin qualification: a glitch of 100ns or less is ignored
    // trade-off: qualifying on synced samples costs two cycles of latency
    assign hw_rst_low = ~pin_s[PIN_RST_N];
    assign rst_qualified = hw_rst_low && (low_cnt_ff == RST_CNT_W'(RST_QUAL_CYC));

    always_comb
    begin
        nxt_low_cnt = low_cnt_ff;
        nxt_in_reset = in_reset_ff;
        if (!hw_rst_low)
        begin
            nxt_low_cnt = '0;
            nxt_in_reset = 1'b0;
        end
        else if (rst_qualified)
        begin
            nxt_in_reset = 1'b1;
        end
        else
        begin
            nxt_low_cnt = low_cnt_ff + RST_CNT_W'(1);
        end
    end

    // [RULE_08] reset after low longer than 100ns
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            low_cnt_ff <= '0;
            in_reset_ff <= 1'b1;
        end
        else
        begin
            low_cnt_ff <= nxt_low_cnt;
            in_reset_ff <= nxt_in_reset;
        end
    end

    // mode pins are straps; a change mid-run is simply decoded again
    // [RULE_11] control interface decode
    always_comb
    begin
        case ({pin_s[PIN_MODE_HI], pin_s[PIN_MODE_LO]})
            2'h0: nxt_mode = IF_HW;
            2'h1: nxt_mode = IF_SERIAL;
            2'h2: nxt_mode = IF_PAR_A;
            default: nxt_mode = IF_PAR_B;
        endcase
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            mode_ff <= IF_HW;
        else
            mode_ff <= nxt_mode;
    end

    assign mode_is_hw = (mode_ff == IF_HW);
    assign mode_is_par = (mode_ff == IF_PAR_A) || (mode_ff == IF_PAR_B);

    // [RULE_09] address only honoured in parallel modes
    assign reg_wr = wr_stb && mode_is_par && !in_reset_ff;
    assign reg_rd = rd_stb && mode_is_par && !in_reset_ff;

    // software configuration registers, cleared by the hardware reset too
    // writes during reset are dropped so the host cannot race the clear
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cfg_a_ff <= CFG_RST[7:0];
            cfg_b_ff <= CFG_RST[10:8];
        end
        else if (in_reset_ff)
        begin
            cfg_a_ff <= CFG_RST[7:0];
            cfg_b_ff <= CFG_RST[10:8];
        end
        else if (reg_wr && addr == REG_CFG_A)
            cfg_a_ff <= data_in;
        else if (reg_wr && addr == REG_CFG_B)
            cfg_b_ff <= data_in[2:0];
    end

    assign sw_cfg = {cfg_b_ff, cfg_a_ff};

    // pin-derived configuration, same layout as the register word
    assign pin_cfg[CF_PATT+1:CF_PATT] = {pin_s[PIN_PATT_HI], pin_s[PIN_PATT_LO]};
    assign pin_cfg[CF_RX_POWERDOWN_CH1] = pin_s[PIN_RX_POWERDOWN_CH1];
    assign pin_cfg[CF_RX_POWERDOWN_CH2] = pin_s[PIN_RX_POWERDOWN_CH2];
    assign pin_cfg[CF_JA+1:CF_JA] = {pin_s[PIN_JA_HI], pin_s[PIN_JA_LO]};
    assign pin_cfg[CF_MONITOR_GAIN_SEL_CH1] = pin_s[PIN_MONITOR_GAIN_SEL_CH1];
    assign pin_cfg[CF_MONITOR_GAIN_SEL_CH2] = pin_s[PIN_MONITOR_GAIN_SEL_CH2];
    assign pin_cfg[CF_TERMINATION_SEL_CH1] = pin_s[PIN_TERMINATION_SEL_CH1];
    assign pin_cfg[CF_TERMINATION_SEL_CH2] = pin_s[PIN_TERMINATION_SEL_CH2];
    assign pin_cfg[CF_PULSE_TEMPLATE_SEL_CH2] = pin_s[PIN_PULSE_TEMPLATE_SEL_CH2];

    // hazard: a mode change swaps the source in one cycle, no blending
    // [RULE_04] jitter pins unused in software mode
    // serial mode keeps the register word; its own port lives elsewhere
    assign nxt_eff = mode_is_hw ? pin_cfg : sw_cfg;

    // [RULE_12] settings held at defaults during reset
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            eff_ff <= CFG_RST;
        else if (in_reset_ff)
            eff_ff <= CFG_RST;
        else
            eff_ff <= nxt_eff;
    end

    assign patt = eff_ff[CF_PATT+1:CF_PATT];
    assign ja = eff_ff[CF_JA+1:CF_JA];

    // readback: unmapped addresses read zero
    // status shows the registered mode, i.e. what the decode really uses
    always_comb
    begin
        nxt_rd_data = '0;
        if (addr == REG_CFG_A)
            nxt_rd_data = cfg_a_ff;
        else if (addr == REG_CFG_B)
            nxt_rd_data = {5'h00, cfg_b_ff};
        else if (addr == REG_STATUS)
            nxt_rd_data = {5'h00, ja_enable, mode_ff};
        else if (addr == REG_EFF_A)
            nxt_rd_data = eff_ff[7:0];
        else if (addr == REG_EFF_B)
            nxt_rd_data = {5'h00, eff_ff[10:8]};
    end

    // data_out idles at zero so a late host latch picks up nothing stale
    // [RULE_10] drive data pins for one cycle on read
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            rd_data_ff <= '0;
            rd_oe_ff <= 1'b0;
        end
        else
        begin
            rd_data_ff <= reg_rd ? nxt_rd_data : 8'h00;
            rd_oe_ff <= reg_rd;
        end
    end

    // decoded outputs, each registered
    // one flop stage keeps the pins glitch free while the decode settles
    // narrow bandwidth and deep fifo coincide today, kept apart for the analog side
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            tx_normal_ch2 <= 1'b1;
            tx_all_ones_ch2 <= 1'b0;
            tx_prbs_ch2 <= 1'b0;
            tx_powerdown_ch2 <= 1'b0;
            rx_pd_ch1 <= 1'b0;
            rx_pd_ch2 <= 1'b0;
            ja_enable <= 1'b0;
            ja_in_tx <= 1'b0;
            ja_narrow_bw <= 1'b0;
            ja_fifo_128 <= 1'b0;
            mon_gain_26db_ch1 <= 1'b0;
            mon_gain_26db_ch2 <= 1'b0;
            ext_match_ch1 <= 1'b0;
            ext_match_ch2 <= 1'b0;
            imp_120_ch2 <= ~PULS_120_LEVEL;
        end
        else
        begin
            // [RULE_01] pattern decode
            tx_normal_ch2 <= (patt == PATT_NORMAL);
            tx_all_ones_ch2 <= (patt == PATT_ONES);
            tx_prbs_ch2 <= (patt == PATT_PRBS);
            tx_powerdown_ch2 <= (patt == PATT_TXPD);
            // [RULE_02] receiver power down
            rx_pd_ch1 <= eff_ff[CF_RX_POWERDOWN_CH1];
            rx_pd_ch2 <= eff_ff[CF_RX_POWERDOWN_CH2];
            // [RULE_03] attenuator position and depth
            ja_enable <= (ja != JA_OFF);
            ja_in_tx <= (ja == JA_TX_NARROW);
            ja_narrow_bw <= (ja == JA_RX_NARROW) || (ja == JA_TX_NARROW);
            ja_fifo_128 <= (ja == JA_RX_NARROW) || (ja == JA_TX_NARROW);
            // [RULE_05] monitor gain select
            mon_gain_26db_ch1 <= eff_ff[CF_MONITOR_GAIN_SEL_CH1];
            mon_gain_26db_ch2 <= eff_ff[CF_MONITOR_GAIN_SEL_CH2];
            // [RULE_06] matching network select
            ext_match_ch1 <= eff_ff[CF_TERMINATION_SEL_CH1];
            ext_match_ch2 <= eff_ff[CF_TERMINATION_SEL_CH2];
            // [RULE_07] template and impedance together
            imp_120_ch2 <= (eff_ff[CF_PULSE_TEMPLATE_SEL_CH2] == PULS_120_LEVEL);
        end
    end

    assign data_out = rd_data_ff;
    assign data_oe = rd_oe_ff;
    assign dev_in_reset = in_reset_ff;
    assign ctrl_if_mode = mode_ff;

endmodule // hmcd_top
`default_nettype wire
